// >>> window_watchdog_fsm.sv
// Window watchdog state machine with debouncers and an AXI4-Lite status port.
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps

module wwd_debounce #(
	parameter int   N    = 3,
	parameter logic INIT = 1'b0
) (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic raw,
	output logic      level
);
	logic [7:0] cnt_ff;
	wire        differ = (raw != level);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt_ff <= 8'h00;
			level  <= INIT;
		end else if (!differ) begin
			cnt_ff <= 8'h00;
		end else if (cnt_ff == 8'(N - 1)) begin
			cnt_ff <= 8'h00;
			level  <= raw;
		end else begin
			cnt_ff <= cnt_ff + 8'h01;
		end
	end
endmodule

module window_watchdog_fsm
	import wwd_pkg::*;
#(
	parameter int SHORT_OPEN_CYC   = 250,
	parameter int LONG_DISABLE_CYC = 20000,
	parameter int LONG_OPEN_CYC    = 20000,
	parameter int RESET_PULSE_CYC  = 64,
	parameter int TMR_W            = 24
) (
	// Clock and supply reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [7:0]  awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	// AXI4-Lite read
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [7:0]  araddr,
	input  wire logic [2:0]  arprot,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	// Controller pins
	input  wire logic        wake_pin,
	input  wire logic        kick_input,
	input  wire logic        mode_pin,
	output logic             safe_permit_out,
	input  wire logic        rst_pin_sense,
	output logic             rst_pin_drive,
	output logic             rst_pin_oe_n
);

	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
		addr_is = (a[7:2] == ofs[7:2]);
	endfunction

	function automatic logic [TMR_W-1:0] lim(input wd_state_t s);
		case (s)
			ST_PWRUP:      lim = TMR_W'(POWER_UP_RESET_CYC);
			ST_MODE_SW:    lim = TMR_W'(MODE_SWITCH_CYC);
			ST_RST:        lim = TMR_W'(RESET_PULSE_CYC);
			ST_SHORT_DIS:  lim = TMR_W'(SHORT_DISABLE_CYC);
			ST_SHORT_OPEN: lim = TMR_W'(SHORT_OPEN_CYC);
			ST_LONG_DIS:   lim = TMR_W'(LONG_DISABLE_CYC);
			ST_LONG_OPEN:  lim = TMR_W'(LONG_OPEN_CYC);
			default:       lim = TMR_W'(MODE_SWITCH_CYC);
		endcase
	endfunction

	wd_state_t             state_ff;
	wd_state_t             nxt_state;
	logic [TMR_W-1:0]      timer_ff;
	logic                  changed_ff;
	logic                  tmo_ff;
	logic                  kick_db;
	logic                  mode_db;
	logic                  wake_db;
	logic                  kick_prev_ff;
	logic                  wake_prev_ff;
	logic [KICK_CNT_W-1:0] low_cnt_ff;
	logic [KICK_CNT_W-1:0] nxt_low_cnt;
	logic [1:0]            good_ff;
	logic [1:0]            nxt_good;
	logic                  permit_ff;
	logic                  rst_oe_n_ff;
	logic                  force_ff;
	logic                  aw_got_ff;
	logic                  w_got_ff;
	logic [7:0]            awaddr_ff;
	logic [31:0]           wdata_ff;
	logic                  wstrb0_ff;
	logic                  bvalid_ff;
	logic [1:0]            bresp_ff;
	logic                  rvalid_ff;
	logic [31:0]           rdata_ff;
	logic [1:0]            rresp_ff;

	// Only the debounced levels feed the machine.
	wwd_debounce #(.N(KICK_DEB_CYC), .INIT(KICK_DB_RST)) u_kick_db (
		.clk   (aclk),
		.rstn  (aresetn),
		.raw   (kick_input),
		.level (kick_db)
	);
	wwd_debounce #(.N(MODE_DEB_CYC), .INIT(MODE_DB_RST)) u_mode_db (
		.clk   (aclk),
		.rstn  (aresetn),
		.raw   (mode_pin),
		.level (mode_db)
	);
	wwd_debounce #(.N(WAKE_DEB_CYC), .INIT(WAKE_DB_RST)) u_wake_db (
		.clk   (aclk),
		.rstn  (aresetn),
		.raw   (wake_pin),
		.level (wake_db)
	);

	// Input events.
	wire kick_valid = kick_db & ~kick_prev_ff;
	wire kick_fault = ~kick_db & (low_cnt_ff == KICK_CNT_W'(KICK_MAX_CYC));
	wire wake_ev    = wake_db ^ wake_prev_ff;
	wire in_long    = (state_ff == ST_LONG_DIS) || (state_ff == ST_LONG_OPEN);
	wire long_err   = force_ff | wake_ev | kick_fault;

	// The timer is cleared one cycle late, so the compare is masked in the first cycle of a new state.
	wire tmo_nxt = ~changed_ff & (timer_ff == lim(state_ff) - TMR_W'(TMO_LEAD_CYC));
	wire [TMR_W-1:0] nxt_timer = changed_ff ? '0 : timer_ff + TMR_W'(1);

	assign nxt_low_cnt = kick_db ? '0 :
		(low_cnt_ff > KICK_CNT_W'(KICK_MAX_CYC)) ? low_cnt_ff : low_cnt_ff + KICK_CNT_W'(1);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_PWRUP: begin
				if (tmo_ff) nxt_state = ST_MODE_SW;
			end
			ST_MODE_SW: begin
				if (force_ff) nxt_state = ST_RST;
				else if (!mode_db) nxt_state = ST_SHORT_DIS;
				else if (tmo_ff) nxt_state = ST_RST;
			end
			ST_RST: begin
				if (tmo_ff) nxt_state = ST_MODE_SW;
			end
			ST_SHORT_DIS: begin
				if (force_ff | kick_valid | kick_fault) nxt_state = ST_RST;
				else if (mode_db) nxt_state = ST_LONG_DIS;
				else if (tmo_ff) nxt_state = ST_SHORT_OPEN;
			end
			ST_SHORT_OPEN: begin
				if (force_ff | kick_fault) nxt_state = ST_RST;
				else if (kick_valid) nxt_state = ST_SHORT_DIS;
				else if (mode_db) nxt_state = ST_LONG_DIS;
				else if (tmo_ff) nxt_state = ST_RST;
			end
			ST_LONG_DIS: begin
				if (long_err | kick_valid) nxt_state = ST_RST;
				else if (!mode_db) nxt_state = ST_SHORT_DIS;
				else if (tmo_ff) nxt_state = ST_LONG_OPEN;
			end
			ST_LONG_OPEN: begin
				if (long_err) nxt_state = ST_RST;
				else if (kick_valid) nxt_state = ST_LONG_DIS;
				else if (!mode_db) nxt_state = ST_SHORT_DIS;
				else if (tmo_ff) nxt_state = ST_RST;
			end
			default: nxt_state = ST_RST;
		endcase
	end

	// Good kicks count up to three; any error or the long window starts the count over.
	wire good_kick = (state_ff == ST_SHORT_OPEN) && (nxt_state == ST_SHORT_DIS);
	wire err_next  = (nxt_state == ST_RST);
	wire nxt_short = (nxt_state == ST_SHORT_DIS) || (nxt_state == ST_SHORT_OPEN);
	assign nxt_good = (err_next || in_long) ? 2'h0 :
		(good_kick && good_ff != GOOD_FULL) ? good_ff + 2'h1 : good_ff;
	wire nxt_permit   = (nxt_good == GOOD_FULL) && nxt_short;
	wire nxt_rst_oe_n = ~((nxt_state == ST_PWRUP) || err_next);

	// Supply reset puts every register to its start value and drives the reset pin.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff     <= ST_PWRUP;
			timer_ff     <= '0;
			changed_ff   <= 1'b1;
			tmo_ff       <= 1'b0;
			kick_prev_ff <= KICK_DB_RST;
			wake_prev_ff <= WAKE_DB_RST;
			low_cnt_ff   <= '0;
			good_ff      <= 2'h0;
			permit_ff    <= 1'b0;
			rst_oe_n_ff  <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			timer_ff     <= nxt_timer;
			changed_ff   <= (nxt_state != state_ff);
			tmo_ff       <= tmo_nxt;
			kick_prev_ff <= kick_db;
			wake_prev_ff <= wake_db;
			low_cnt_ff   <= nxt_low_cnt;
			good_ff      <= nxt_good;
			permit_ff    <= nxt_permit;
			rst_oe_n_ff  <= nxt_rst_oe_n;
		end
	end

	// Open-drain reset: the pin only ever pulls low.
	assign rst_pin_drive   = 1'b0;
	assign rst_pin_oe_n    = rst_oe_n_ff;
	assign safe_permit_out = permit_ff;

	// Register bus. Write address and data may arrive in either order.
	wire aw_hs    = awvalid & awready;
	wire w_hs     = wvalid & wready;
	wire do_write = aw_got_ff & w_got_ff & ~bvalid_ff;
	wire wr_ctrl  = addr_is(awaddr_ff, CTRL_OFS);
	wire wr_hit   = wr_ctrl | addr_is(awaddr_ff, STATUS_OFS);
	wire ar_hs    = arvalid & arready;
	wire rd_hit   = addr_is(araddr, STATUS_OFS) | addr_is(araddr, CTRL_OFS);
	wire [31:0] status_word = {20'h00000, rst_pin_sense, good_ff, wake_db, kick_db, mode_db,
		~rst_oe_n_ff, permit_ff, 1'b0, state_ff};
	wire [31:0] rd_word = addr_is(araddr, STATUS_OFS) ? status_word : 32'h00000000;

	assign awready = ~aw_got_ff & ~bvalid_ff;
	assign wready  = ~w_got_ff & ~bvalid_ff;
	assign bvalid  = bvalid_ff;
	assign bresp   = bresp_ff;
	assign arready = ~rvalid_ff;
	assign rvalid  = rvalid_ff;
	assign rdata   = rdata_ff;
	assign rresp   = rresp_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff <= 1'b0;
			w_got_ff  <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff  <= 32'h00000000;
			wstrb0_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
			force_ff  <= 1'b0;
		end else begin
			force_ff <= do_write & wr_ctrl & wstrb0_ff & wdata_ff[CTRL_FORCE_BIT];
			if (aw_hs) begin
				aw_got_ff <= 1'b1;
				awaddr_ff <= awaddr;
			end
			if (w_hs) begin
				w_got_ff  <= 1'b1;
				wdata_ff  <= wdata;
				wstrb0_ff <= wstrb[0];
			end
			if (do_write) begin
				aw_got_ff <= 1'b0;
				w_got_ff  <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_ff && bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h00000000;
			rresp_ff  <= RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rd_word;
			rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_ff && rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_rst_end;
		(state_ff == ST_RST) && tmo_ff;
	endsequence

	sequence s_short_early;
		(state_ff == ST_SHORT_DIS) && kick_valid;
	endsequence

	sequence s_open_lapse;
		(state_ff == ST_SHORT_OPEN) && tmo_ff && !kick_valid && !mode_db;
	endsequence

	sequence s_short_fault;
		(state_ff == ST_SHORT_DIS || state_ff == ST_SHORT_OPEN) && kick_fault;
	endsequence

	sequence s_mode_high;
		(state_ff == ST_SHORT_DIS || state_ff == ST_SHORT_OPEN) && mode_db
			&& !kick_valid && !kick_fault && !force_ff;
	endsequence

	a_long_no_permit: assert property (in_long |-> !safe_permit_out)
		else $error("permit high in long window");

	a_permit_three: assert property ($rose(safe_permit_out) |-> good_ff == GOOD_FULL)
		else $error("permit rose without three kicks");

	a_err_drops_permit: assert property ((state_ff == ST_RST) |-> !safe_permit_out && good_ff == 2'h0)
		else $error("permit not cleared by error");

	a_reset_pin_held: assert property ((state_ff == ST_PWRUP) || (state_ff == ST_RST) |-> !rst_pin_oe_n)
		else $error("reset pin not driven");

	a_rst_resync: assert property (s_rst_end |=> (state_ff == ST_MODE_SW) ##1 (timer_ff == '0))
		else $error("reset pulse not followed by mode switch");

	a_mode_lapse: assert property ((state_ff == ST_MODE_SW) && tmo_ff && mode_db |=> state_ff == ST_RST)
		else $error("mode timeout without reset");

	a_early_kick: assert property (s_short_early |=> state_ff == ST_RST && !rst_pin_oe_n)
		else $error("early kick not punished");

	a_open_lapse: assert property (s_open_lapse |=> state_ff == ST_RST)
		else $error("missing kick not punished");

	a_kick_too_long: assert property (s_short_fault |=> state_ff == ST_RST)
		else $error("overlong kick not punished");

	a_wake_long: assert property (in_long && wake_ev |=> state_ff == ST_RST)
		else $error("wake in long window without reset");

	a_timer_restart: assert property ($changed(state_ff) |=> timer_ff == '0)
		else $error("timer not restarted");

	a_mode_to_long: assert property (s_mode_high |=> state_ff == ST_LONG_DIS)
		else $error("mode high did not enter long window");

endmodule

// >>> wwd_pkg.sv
// Shared constants and types of the window watchdog.
package wwd_pkg;

	// Fixed timing counts, in oscillator cycles, and the kick counter width.
	localparam int POWER_UP_RESET_CYC  = 201;
	localparam int MODE_SWITCH_CYC     = 1112;
	localparam int SHORT_DISABLE_CYC   = 130;
	localparam int KICK_MAX_CYC        = 45;
	localparam int KICK_DEB_CYC        = 3;
	localparam int MODE_DEB_CYC        = 3;
	localparam int WAKE_DEB_CYC        = 96;
	localparam int KICK_CNT_W          = 6;
	localparam int TMO_LEAD_CYC        = 3;

	// Register map, byte addresses.
	localparam logic [7:0] STATUS_OFS  = 8'h00;
	localparam logic [7:0] CTRL_OFS    = 8'h04;

	// Status word field positions.
	localparam int STS_STATE_LSB       = 0;
	localparam int STS_PERMIT_BIT      = 4;
	localparam int STS_RST_BIT         = 5;
	localparam int STS_MODE_BIT        = 6;
	localparam int STS_KICK_BIT        = 7;
	localparam int STS_WAKE_BIT        = 8;
	localparam int STS_GOOD_LSB        = 9;
	localparam int STS_PIN_BIT         = 11;

	// Control word field positions.
	localparam int CTRL_FORCE_BIT      = 0;

	// Reset values and the full good-kick count.
	localparam logic       KICK_DB_RST = 1'b1;
	localparam logic       MODE_DB_RST = 1'b1;
	localparam logic       WAKE_DB_RST = 1'b0;
	localparam logic [1:0] GOOD_FULL   = 2'h3;

	// Bus responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_PWRUP,
		ST_MODE_SW,
		ST_RST,
		ST_SHORT_DIS,
		ST_SHORT_OPEN,
		ST_LONG_DIS,
		ST_LONG_OPEN
	} wd_state_t;

endpackage

// >>> mcu_model.sv
// Controller model that drives the kick, mode and wake lines of the watchdog.
`timescale 1ns/1ps
module mcu_model (
	// Clock
	input  wire logic aclk,
	// Lines towards the watchdog
	output logic      kick_input,
	output logic      mode_pin,
	output logic      wake_pin
);
	// Idle levels follow the pull resistors of the pins.
	initial begin
		kick_input = 1'b1;
		mode_pin   = 1'b1;
		wake_pin   = 1'b0;
	end
	// A trigger is a low pulse; its rising edge is the kick.
	task automatic pulse(input int len);
		@(posedge aclk);
		kick_input <= 1'b0;
		repeat (len) @(posedge aclk);
		kick_input <= 1'b1;
	endtask
	// Low asks for the short window, high for the long one.
	task automatic set_mode(input logic lvl);
		@(posedge aclk);
		mode_pin <= lvl;
	endtask
	task automatic toggle_wake();
		@(posedge aclk);
		wake_pin <= !wake_pin;
	endtask
endmodule

// >>> window_watchdog_fsm_tb.sv
// Self-checking bench of the window watchdog with a controller model on its pins.
`timescale 1ns/1ps
module window_watchdog_fsm_tb
	import wwd_pkg::*;
;
	localparam int OPEN_C = 60;
	localparam int PULSE_C = 8;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0]  bresp, rresp, rs;
	logic        kick_input, mode_pin, wake_pin, safe_permit_out, rst_pin_drive, rst_pin_oe_n, rst_wire, prv;
	logic [2:0]  awprot, arprot;
	logic [3:0]  wstrb;
	int          num_errors = 0, total_checks = 0, cyc = 0, cnt = 0, n_pulse = 0;
	int          lo_len, hi_len, fall_cyc, exp_good = 0, t;
	// The reset pin is open drain with a pull-up.
	assign rst_wire = rst_pin_oe_n ? 1'b1 : rst_pin_drive;
	window_watchdog_fsm #(.SHORT_OPEN_CYC(OPEN_C), .LONG_DISABLE_CYC(100), .LONG_OPEN_CYC(300),
		.RESET_PULSE_CYC(PULSE_C), .TMR_W(24)) dut_u (
		.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.wake_pin(wake_pin), .kick_input(kick_input), .mode_pin(mode_pin),
		.safe_permit_out(safe_permit_out), .rst_pin_sense(rst_wire), .rst_pin_drive(rst_pin_drive),
		.rst_pin_oe_n(rst_pin_oe_n));
	mcu_model mcu_u (.aclk(aclk), .kick_input(kick_input), .mode_pin(mode_pin), .wake_pin(wake_pin));
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	// Run lengths of the reset pin, counted only while the supply reset is released.
	always @(posedge aclk) begin
		cyc++;
		if (!aresetn) begin
			cnt = 0;
			prv = 1'b0;
		end else if (rst_pin_oe_n !== prv) begin
			if (prv) begin
				hi_len = cnt;
				n_pulse++;
				fall_cyc = cyc;
			end else lo_len = cnt;
			cnt = 1;
			prv = rst_pin_oe_n;
		end else cnt++;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s: seen %0h expected %0h", $time, what, seen, exp);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done  = 1'b0;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr  <= a;
		awprot  <= 3'($urandom);
		wvalid  <= 1'b1;
		wdata   <= d;
		wstrb   <= s;
		bready  <= 1'b1;
		// Each channel is released at the edge at which it is taken, never earlier.
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && awready) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr  <= a;
		arprot  <= 3'($urandom);
		rready  <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic wait_st(input wd_state_t s);
		for (int i = 0; i < 2000; i++) begin
			axi_rd(STATUS_OFS, rd, rs);
			if (rd[2:0] === s) break;
		end
		check(rd[2:0], s, "state reached");
	endtask
	task automatic wait_pulse(input int n);
		for (int i = 0; i < 3000 && n_pulse < n; i++) @(posedge aclk);
		check(n_pulse, n, "reset pulse count");
	endtask
	// Bench model of the good-kick count: saturates at three, any pulse or long mode clears it.
	task automatic good_kicks(input int n);
		for (int k = 0; k < n; k++) begin
			wait_st(ST_SHORT_OPEN);
			mcu_u.pulse(4 + $urandom % 12);
			exp_good = (exp_good < 3) ? exp_good + 1 : 3;
			wait_st(ST_SHORT_DIS);
			axi_rd(STATUS_OFS, rd, rs);
			check(rd[10:9], exp_good, "good count");
			check(safe_permit_out, exp_good == 3, "permit");
		end
	endtask
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge aclk);
		num_errors++;
		complete_run();
	end
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		awaddr  = 8'h00;
		araddr  = 8'h00;
		wdata   = 32'h0;
		{awprot, arprot, wstrb} = 10'h000;
		aresetn = 1'b0;
		void'($urandom(72849));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		// Mode stays high, so the switch-over period has to run out.
		wait_pulse(1);
		check(lo_len, POWER_UP_RESET_CYC, "power-up reset length");
		check(hi_len, 1112, "switch-over length");
		repeat (PULSE_C + 2) @(posedge aclk);
		check(lo_len, PULSE_C, "reset pulse length");
		axi_rd(STATUS_OFS, rd, rs);
		check(rd[2:0], ST_MODE_SW, "restart switch-over");
		check({rd[11], rd[3]}, 2'h2, "pin readback");
		mcu_u.set_mode(1'b0);
		wait_st(ST_SHORT_DIS);
		good_kicks(4);
		check(n_pulse, 1, "no spurious pulse");
		$display("good kicks done");
		mcu_u.pulse(5);
		exp_good = 0;
		wait_pulse(2);
		check(safe_permit_out, 1'b0, "permit cleared");
		wait_st(ST_SHORT_DIS);
		wait_st(ST_SHORT_OPEN);
		t = cyc;
		wait_pulse(3);
		check(fall_cyc - t >= OPEN_C - 6 && fall_cyc - t <= OPEN_C + 2, 1, "missing kick timing");
		wait_st(ST_SHORT_DIS);
		t = cyc;
		mcu_u.pulse(70);
		check(n_pulse, 4, "long kick pulse");
		check(fall_cyc - t >= 46 && fall_cyc - t <= 60, 1, "long kick timing");
		wait_pulse(5);
		$display("kick errors done");
		// A forced pulse is not taken during a reset pulse, so let the last one end first.
		wait_st(ST_SHORT_DIS);
		axi_wr(CTRL_OFS, 32'h1, 4'hF, rs);
		check(rs, RESP_OKAY, "ctrl write");
		wait_pulse(6);
		axi_rd(CTRL_OFS, rd, rs);
		check(rd, 32'h0, "ctrl self clears");
		axi_wr(8'h10, 32'h1, 4'($urandom), rs);
		check(rs, RESP_SLVERR, "unmapped write");
		axi_rd(8'h10, rd, rs);
		check(rs, RESP_SLVERR, "unmapped read response");
		check(rd, 32'h0, "unmapped read data");
		axi_wr(STATUS_OFS, 32'hFFFFFFFF, 4'hF, rs);
		check({rs, n_pulse[3:0]}, {RESP_OKAY, 4'h6}, "status write ignored");
		// Without the low strobe bit the force bit must not land.
		axi_wr(CTRL_OFS, 32'h1, 4'hE, rs);
		repeat (4) @(posedge aclk);
		check({rs, n_pulse[3:0]}, {RESP_OKAY, 4'h6}, "masked force ignored");
		$display("register tests done");
		wait_st(ST_SHORT_DIS);
		good_kicks(3);
		mcu_u.set_mode(1'b1);
		wait_st(ST_LONG_DIS);
		check(safe_permit_out, 1'b0, "permit in long");
		wait_st(ST_LONG_OPEN);
		mcu_u.pulse(6);
		wait_st(ST_LONG_DIS);
		check(safe_permit_out, 1'b0, "permit in long");
		mcu_u.set_mode(1'b0);
		wait_st(ST_SHORT_DIS);
		axi_rd(STATUS_OFS, rd, rs);
		check({safe_permit_out, rd[10:9]}, 3'h0, "count cleared by long");
		exp_good = 0;
		mcu_u.set_mode(1'b1);
		wait_st(ST_LONG_OPEN);
		t = cyc;
		mcu_u.toggle_wake();
		wait_pulse(7);
		check(fall_cyc - t >= 96, 1, "wake debounce");
		axi_rd(STATUS_OFS, rd, rs);
		check({rd[11], rd[2:0]}, {1'b0, ST_RST}, "wake reset pulse");
		wait_st(ST_MODE_SW);
		mcu_u.set_mode(1'b0);
		wait_st(ST_SHORT_DIS);
		$display("long window done");
		// Supply drop in mid-run with the permit up: everything starts over with a power-up pulse.
		good_kicks(3);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		exp_good = 0;
		wait_st(ST_SHORT_DIS);
		check(lo_len, POWER_UP_RESET_CYC, "power-up after drop");
		check({safe_permit_out, rd[10:9]}, 3'h0, "state after drop");
		$display("supply drop done");
		complete_run();
	end
endmodule
